// ---- design/mic_top.sv ----
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "mic_regs.svh"
// ==========================================
// Interrupt controller top
// ==========================================
// Notes on behaviour
// RULE1: nine request sources are collected
// RULE2: flags set regardless of any enable
// RULE3: global enable gates every request
// RULE4: enabled pending flag vectors at once
// RULE5: reset clears the global enable
// RULE6: return from service sets global enable
// RULE7: peripheral flags, enables, group enable
// RULE8: accept clears enable, pushes, loads vector
// RULE9: software clears flags before re-enabling
// RULE10: pin events reach vector in 3-4 cycles
// RULE11: pin edge polarity chosen by option bit
// RULE12: pin edge sets flag, enable gates
// RULE13: enabled pin flag wakes the core
// RULE14: timer0 rollover sets flag, enable gates
// RULE15: upper port change sets flag
// RULE16: only return address pushed on entry
// RULE17: masked-by-global request stays pending
module mic_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic ext_irq_pin,
  input wire logic [3:0] upper_port_pins,
  input wire logic [7:0] timer0_count,
  input wire mic_pkg::mic_periph_t periph_evt,
  input wire logic return_from_irq,
  output logic irq_req,
  output logic vec_load,
  output logic stack_push,
  output mic_pkg::mic_pc_t vec_addr,
  output logic wake_req,
  output logic in_service
);
  import mic_pkg::*;

  // ==========================================
  // Bus slave state
  // ==========================================
  logic wr_en_r; // Write data phase pending
  logic [7:0] wr_addr_r; // Latched write offset
  logic addr_ok; // Address phase accepted
  logic [7:0] rd_val; // Read mux result

  // ==========================================
  // Control and status state
  // ==========================================
  logic glb_en_r; // global_irq_enable
  logic [3:0] en_r; // Group, timer0, pin and port enables
  logic [5:0] pen_r; // periph_enable_reg
  logic [7:0] opt_r; // option byte
  logic [7:0] t0_prev_r; // Last timer0_count value
  mic_state_t state_r; // Service state
  logic [8:0] flag; // {periph[5:0], timer0_overflow_flag, ext_pin_flag, port_change_flag}
  logic [8:0] fset; // Hardware set per flag
  logic [8:0] fwr; // Software write per flag
  logic [8:0] fwd; // Software write data per flag
  logic peie, t0_en, pin_en, port_en; // Enable aliases
  logic ctl_pend; // Core-group pending
  logic per_pend; // Peripheral-group pending
  logic pending; // Any enabled request
  logic irq_take; // Accept this cycle
  logic wr_ctl, wr_pf, wr_pen, wr_opt; // Write decodes
  logic ext_edge; // Valid pin edge
  logic t0_roll; // Timer0 rollover seen

  // Pin synchronisers
  mic_sync_if #(.W(1)) ext_sy ();
  mic_sync_if #(.W(4)) port_sy ();

  mic_pin_sync #(.W(1)) u_ext_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(ext_irq_pin),
    .sy(ext_sy)
  );

  mic_pin_sync #(.W(4)) u_port_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(upper_port_pins),
    .sy(port_sy)
  );

  // ==========================================
  // AHB-Lite slave: zero wait, always OKAY
  // ==========================================
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // Only NONSEQ/SEQ with hready open a transfer; hsize is not checked
  assign addr_ok = hsel && htrans[1] && hready;

  // Latch write address for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_en_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_en_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  assign wr_ctl = wr_en_r && (wr_addr_r == `MIC_OFS_CTL);
  assign wr_pf = wr_en_r && (wr_addr_r == `MIC_OFS_PFLAG);
  assign wr_pen = wr_en_r && (wr_addr_r == `MIC_OFS_PEN);
  assign wr_opt = wr_en_r && (wr_addr_r == `MIC_OFS_OPT);

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_val = 8'h00;
    unique case (haddr[7:0])
      `MIC_OFS_CTL: begin
        rd_val = {glb_en_r, en_r, flag[2:0]};
      end
      `MIC_OFS_PFLAG: begin
        rd_val = {2'b00, flag[8:3]};
      end
      `MIC_OFS_PEN: begin
        rd_val = {2'b00, pen_r};
      end
      `MIC_OFS_OPT: begin
        rd_val = opt_r;
      end
      `MIC_OFS_STAT: begin
        rd_val = {port_sy.level, ext_sy.level, in_service, wake_req, irq_req};
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  // Read data captured at the address phase, stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= {24'h00_0000, rd_val};
    end
  end

  // ==========================================
  // Software-owned enables and option
  // ==========================================
  // RULE7: peripheral enable register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pen_r <= `MIC_PEN_RST;
    end else if (wr_pen) begin
      pen_r <= hwdata[5:0];
    end
  end

  // Control enables at bits 6..3
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r <= `MIC_EN_RST;
    end else if (wr_ctl) begin
      en_r <= hwdata[`MIC_PEIE_BIT:`MIC_PORT_EN_BIT];
    end
  end

  // Option byte resets to all ones, so rising edge by default
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_r <= `MIC_OPT_RST;
    end else if (wr_opt) begin
      opt_r <= hwdata[7:0];
    end
  end

  assign peie = en_r[`MIC_PEIE_BIT - `MIC_PORT_EN_BIT];
  assign t0_en = en_r[`MIC_T0_EN_BIT - `MIC_PORT_EN_BIT];
  assign pin_en = en_r[`MIC_PIN_EN_BIT - `MIC_PORT_EN_BIT];
  assign port_en = en_r[`MIC_PORT_EN_BIT - `MIC_PORT_EN_BIT];

  // ==========================================
  // Event detection
  // ==========================================
  // RULE11: edge polarity select
  assign ext_edge = opt_r[`MIC_EDGE_BIT] ? ext_sy.rise : ext_sy.fall;

  // Previous timer value, same clock so no synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t0_prev_r <= `MIC_T0_MIN;
    end else begin
      t0_prev_r <= timer0_count;
    end
  end

  // RULE14: rollover detect
  assign t0_roll = (t0_prev_r == `MIC_T0_MAX) && (timer0_count == `MIC_T0_MIN);

  // ==========================================
  // Request flags
  // ==========================================
  // RULE1: nine flag sources
  // RULE12: pin flag set
  // RULE15: port change flag set
  assign fset = {periph_evt, t0_roll, ext_edge, |(port_sy.rise | port_sy.fall)};
  assign fwr = {{6{wr_pf}}, {3{wr_ctl}}};
  assign fwd = {hwdata[5:0], hwdata[`MIC_T0_FLAG_BIT:`MIC_PORT_FLAG_BIT]};

  // RULE2: flags ignore all enables
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_flag
      mic_flag u_flag (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(fset[gi]),
        .wr(fwr[gi]),
        .wdata(fwd[gi]),
        .q(flag[gi])
      );
    end
  endgenerate

  // ==========================================
  // Request gating and acceptance
  // ==========================================
  // RULE12: pin enable gates
  // RULE14: timer0 enable gates
  // RULE15: port change enable gates
  assign ctl_pend = (flag[`MIC_T0_FLAG_BIT] && t0_en) || (flag[`MIC_PIN_FLAG_BIT] && pin_en)
    || (flag[`MIC_PORT_FLAG_BIT] && port_en);
  // RULE7: group enable gates peripherals
  assign per_pend = peie && |(flag[8:3] & pen_r);
  assign pending = ctl_pend || per_pend;

  // RULE3: global enable gate
  // RULE4: vector with no extra delay
  // RULE17: pending held until enabled
  // A flag not cleared before re-enabling re-enters at once
  assign irq_take = glb_en_r && pending;
  assign irq_req = irq_take;

  // RULE13: wake ignores global enable
  assign wake_req = pending;

  // RULE5: reset clears global enable
  // RULE6: return sets global enable
  // RULE8: acceptance clears global enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      glb_en_r <= `MIC_GLB_EN_RST;
    end else if (irq_take) begin
      glb_en_r <= 1'b0;
    end else if (return_from_irq) begin
      glb_en_r <= 1'b1;
    end else if (wr_ctl) begin
      glb_en_r <= hwdata[`MIC_GLB_EN_BIT];
    end
  end

  // RULE8: push and vector load in the same cycle
  // RULE16: only return address pushed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_load <= 1'b0;
      stack_push <= 1'b0;
    end else begin
      vec_load <= irq_take;
      stack_push <= irq_take;
    end
  end

  // Vector is fixed; held in a flop so the output is registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_addr <= `MIC_VECTOR;
    end else begin
      vec_addr <= `MIC_VECTOR;
    end
  end

  // Service tracking, left on return
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= MIC_ST_RUN;
    end else begin
      unique case (state_r)
        MIC_ST_RUN: begin
          if (irq_take) begin
            state_r <= MIC_ST_SERVICE;
          end
        end
        MIC_ST_SERVICE: begin
          if (return_from_irq) begin
            state_r <= MIC_ST_RUN;
          end
        end
      endcase
    end
  end

  assign in_service = (state_r == MIC_ST_SERVICE);

  // ==========================================
  // Checks
  // ==========================================
  AST_GLB_EN_RESET: assert property (@(posedge hclk) // RULE5
    $rose(hresetn) |-> !glb_en_r)
    else $error("global enable set right after reset");

  AST_GLB_EN_BLOCKS: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
    !glb_en_r |-> !irq_req)
    else $error("request issued with global enable clear");

  AST_VECTOR_NOW: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
    (glb_en_r && pending) |-> irq_req ##1 (vec_load && !glb_en_r))
    else $error("enabled pending request not vectored");

  AST_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
    irq_take |=> (stack_push && vec_load && vec_addr == 13'h0004 && in_service))
    else $error("entry sequence wrong");

  AST_RETURN: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
    (return_from_irq && !irq_take) |=> (glb_en_r && !in_service))
    else $error("return did not re-enable");

  AST_PIN_FLAG: assert property (@(posedge hclk) disable iff (!hresetn) // RULE12
    (ext_sy.rise && opt_r[6]) |=> flag[1])
    else $error("rising pin edge did not set pin flag");

  AST_PIN_POL: assert property (@(posedge hclk) disable iff (!hresetn) // RULE11
    (ext_sy.fall && opt_r[6] && !flag[1] && !wr_ctl) |=> !flag[1])
    else $error("wrong pin edge set the flag");

  AST_T0_ROLL: assert property (@(posedge hclk) disable iff (!hresetn) // RULE14
    ($past(timer0_count) == 8'hFF && timer0_count == 8'h00) |=> flag[2])
    else $error("timer0 rollover missed");

  AST_PORT_CHG: assert property (@(posedge hclk) disable iff (!hresetn) // RULE15
    (|(port_sy.rise | port_sy.fall)) |=> flag[0])
    else $error("port change missed");

  AST_PEIE_GATE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
    (!peie && !ctl_pend) |-> !irq_req)
    else $error("peripheral passed with group enable clear");

  AST_WAKE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE13
    (flag[1] && pin_en && !glb_en_r) |-> (wake_req && !irq_req))
    else $error("enabled pin flag did not wake");

  AST_PEND_HOLD: assert property (@(posedge hclk) disable iff (!hresetn) // RULE17
    (pending && !glb_en_r && !wr_en_r) |=> pending)
    else $error("masked request was lost");

  AST_PIN_LAT: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
    (ext_edge && pin_en && glb_en_r && !wr_en_r) |=> irq_req)
    else $error("pin event not vectored in time");
endmodule : mic_top

// ---- inc/mic_regs.svh ----
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH
// ==========================================
// Register byte offsets on the bus
// ==========================================
`define MIC_OFS_CTL 8'h00
`define MIC_OFS_PFLAG 8'h04
`define MIC_OFS_PEN 8'h08
`define MIC_OFS_OPT 8'h0C
`define MIC_OFS_STAT 8'h10
// ==========================================
// Control register field positions
// ==========================================
`define MIC_GLB_EN_BIT 7
`define MIC_PEIE_BIT 6
`define MIC_T0_EN_BIT 5
`define MIC_PIN_EN_BIT 4
`define MIC_PORT_EN_BIT 3
`define MIC_T0_FLAG_BIT 2
`define MIC_PIN_FLAG_BIT 1
`define MIC_PORT_FLAG_BIT 0
// Option register: edge polarity select
`define MIC_EDGE_BIT 6
// ==========================================
// Reset values and constants
// ==========================================
`define MIC_GLB_EN_RST 1'b0
`define MIC_EN_RST 4'h0
`define MIC_PEN_RST 6'h00
`define MIC_OPT_RST 8'hFF
`define MIC_VECTOR 13'h0004
`define MIC_T0_MAX 8'hFF
`define MIC_T0_MIN 8'h00
`endif

// ---- inc/mic_pkg.sv ----
// ==========================================
// Shared types
// ==========================================
package mic_pkg;
  // Service state of the controller
  typedef enum logic {MIC_ST_RUN, MIC_ST_SERVICE} mic_state_t;
  // Six peripheral request lines
  typedef logic [5:0] mic_periph_t;
  // Program counter width of the core
  typedef logic [12:0] mic_pc_t;
endpackage : mic_pkg

// ---- inc/mic_sync_if.sv ----
`timescale 1ns/1ps
// ==========================================
// Synchronised pin level and edge events
// ==========================================
interface mic_sync_if #(parameter int W = 1);
  logic [W-1:0] level; // Settled level
  logic [W-1:0] rise; // One-cycle rising event
  logic [W-1:0] fall; // One-cycle falling event
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : mic_sync_if

// ---- design/mic_pin_sync.sv ----
`timescale 1ns/1ps
// ==========================================
// Three-stage pin synchroniser with edge detect
// ==========================================
module mic_pin_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] pin,
  mic_sync_if.src sy
);
  logic [W-1:0] s1_r; // First stage, read only by s2
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] stable_r; // Last accepted level
  logic init_r; // Stable level captured once
  logic [1:0] fill_r; // Edges since reset, saturates at three
  logic [W-1:0] chg; // Accepted change this cycle

  // Shift chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change counts only once stages two and three agree
  assign chg = init_r ? (~(s2_r ^ s3_r) & (s3_r ^ stable_r)) : '0;

  // Level seen once the chain has filled is taken silently, no false edge;
  // a pin held high through reset would otherwise look like a rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stable_r <= '0;
      init_r <= 1'b0;
      fill_r <= 2'h0;
    end else begin
      if (fill_r != 2'h3) begin
        fill_r <= fill_r + 2'h1;
      end
      init_r <= (fill_r == 2'h3);
      stable_r <= init_r ? (stable_r ^ chg) : s3_r;
    end
  end

  assign sy.level = stable_r;
  assign sy.rise = chg & s3_r;
  assign sy.fall = chg & ~s3_r;

  // RULE10: one event per change
  AST_SYNC_ONE_EVENT: assert property (@(posedge hclk) disable iff (!hresetn)
    (|chg) |=> ((chg & $past(chg)) == '0)) // RULE10
    else $error("sync reported the same change twice");
endmodule : mic_pin_sync

// ---- design/mic_flag.sv ----
`timescale 1ns/1ps
// ==========================================
// Sticky request flag, hardware set wins
// ==========================================
module mic_flag (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic set,
  input wire logic wr,
  input wire logic wdata,
  output logic q
);
  // A write in the same cycle as an event cannot lose the event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (wr) begin
      q <= wdata;
    end
  end

  // RULE2: set regardless of enables
  AST_FLAG_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    set |=> q) // RULE2
    else $error("flag not set after its event");
endmodule : mic_flag

// ---- bench/mic_core_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Core sequencer stand-in
// ==========================================
module mic_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic vec_load,
  input wire logic stack_push,
  input wire mic_pkg::mic_pc_t vec_addr,
  input wire logic ret_go,
  output logic return_from_irq,
  output logic [3:0] depth
);
  import mic_pkg::*;
  mic_pc_t pc_r; // Fetch address of the core
  // vector load, only the pc pushed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_r <= 13'h0100;
      depth <= 4'h0;
    end else begin
      // Push and pop may not meet, so one adder is enough
      if (vec_load) begin
        pc_r <= vec_addr;
      end else begin
        pc_r <= pc_r + 13'h0001;
      end
      if (stack_push) begin
        depth <= depth + 4'h1;
      end else if (return_from_irq) begin
        depth <= depth - 4'h1;
      end
    end
  end
  // one-cycle return pulse when the bench asks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      return_from_irq <= 1'b0;
    end else begin
      return_from_irq <= ret_go;
    end
  end
endmodule : mic_core_model

// ---- bench/mic_top_test.sv ----
`timescale 1ns/1ps
`include "mic_regs.svh"
module mic_top_test;
  import mic_pkg::*;
  // ==========================================
  // Signals
  // ==========================================
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ext_irq_pin, ret_go;
  logic return_from_irq, irq_req, vec_load, stack_push, wake_req, in_service;
  logic [31:0] haddr, hwdata, hrdata, rd_val;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] upper_port_pins, depth;
  logic [7:0] timer0_count;
  mic_periph_t periph_evt;
  mic_pc_t vec_addr;
  int mismatches, checks_done, n;
  logic [31:0] rq[$]; // Expected read data, oldest first
  mic_pc_t vq[$]; // Expected vector loads
  logic [31:0] seed = 32'h0EC18BBF; // Fixed seed for repeatable runs
  event rd_ev;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  mic_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .ext_irq_pin, .upper_port_pins,
    .timer0_count, .periph_evt, .return_from_irq, .irq_req, .vec_load, .stack_push,
    .vec_addr, .wake_req, .in_service);
  mic_core_model u_core (.hclk, .hresetn, .vec_load, .stack_push, .vec_addr, .ret_go,
    .return_from_irq, .depth);
  // ==========================================
  // Helpers
  // ==========================================
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Address phase held until ready is seen at an edge
  task automatic addr_ph(logic [31:0] a, logic w);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask : addr_ph
  task automatic bus_wr(logic [31:0] a, logic [31:0] d);
    addr_ph(a, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : bus_wr
  // Note the expectation, then hand the data to the watcher
  task automatic bus_rd(logic [31:0] a, logic [31:0] e);
    rq.push_back(e);
    addr_ph(a, 1'b0);
    do @(posedge hclk); while (hready !== 1'b1);
    rd_val = hrdata;
    -> rd_ev;
  endtask : bus_rd
  // Bounded wait until the queue of vectors shrinks to left
  task automatic drain(int left, int lim);
    n = 0;
    while (vq.size() > left && n < lim) begin
      @(posedge hclk);
      n++;
    end
    check("vector taken", vq.size(), left);
  endtask : drain
  task automatic ret_irq();
    ret_go <= 1'b1;
    @(posedge hclk);
    ret_go <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : ret_irq
  // ==========================================
  // Clock, watchers, watchdog
  // ==========================================
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    forever begin
      @(rd_ev);
      check("read data", rd_val, rq.pop_front());
      check("okay response", hresp, 1'b0);
    end
  end
  // Sampled mid-cycle so registered pulses have settled
  always @(negedge hclk) begin
    if (vec_load === 1'b1) begin
      check("push with load", stack_push, 1'b1);
      // An empty queue means a request got through a closed gate
      if (vq.size() == 0) check("unexpected vector", 1, 0);
      else check("vector", vec_addr, vq.pop_front());
    end
  end
  initial begin
    #(50 * 20000);
    mismatches++;
    close_out();
  end
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    {hresetn, hsel, hwrite, ext_irq_pin, ret_go} = '0;
    {haddr, hwdata, htrans, upper_port_pins, timer0_count, periph_evt} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    bus_rd(`MIC_OFS_CTL, 32'h00);
    bus_rd(`MIC_OFS_OPT, 32'hFF);
    bus_rd(`MIC_OFS_PEN, 32'h00);
    bus_wr(32'h14, 32'hFFFFFFFF);
    bus_rd(32'h14, 32'h00);
    // Timer noise that never wraps, then one rollover
    repeat (5) begin
      timer0_count <= 8'(rnd() & 32'h7F);
      @(posedge hclk);
    end
    timer0_count <= 8'hFF;
    @(posedge hclk);
    timer0_count <= 8'h00;
    repeat (2) @(posedge hclk);
    bus_rd(`MIC_OFS_CTL, 32'h04);
    bus_wr(`MIC_OFS_CTL, 32'h24);
    repeat (4) @(posedge hclk);
    check("wake while masked", wake_req, 1'b1);
    vq.push_back(`MIC_VECTOR);
    vq.push_back(`MIC_VECTOR);
    bus_wr(`MIC_OFS_CTL, 32'hA4);
    drain(1, 3);
    bus_rd(`MIC_OFS_CTL, 32'h24);
    // In service, masked request still asks for wake
    bus_rd(`MIC_OFS_STAT, 32'h06);
    // Returning with the flag still set enters again
    ret_irq();
    drain(0, 6);
    bus_wr(`MIC_OFS_CTL, 32'h20);
    ret_irq();
    bus_rd(`MIC_OFS_CTL, 32'hA0);
    check("stack depth", depth, 4'h0);
    bus_wr(`MIC_OFS_CTL, 32'h00);
    // Pin edge, rising then falling select
    for (int s = 1; s >= 0; s--) begin
      bus_wr(`MIC_OFS_OPT, s ? 32'hFF : 32'hBF);
      ext_irq_pin <= ~s[0];
      repeat (6 + rnd() % 4) @(posedge hclk);
      bus_wr(`MIC_OFS_CTL, 32'h90);
      vq.push_back(`MIC_VECTOR);
      ext_irq_pin <= s[0];
      n = 0;
      do begin
        @(posedge hclk);
        #1;
        n++;
      end while (irq_req !== 1'b1 && n < 20);
      check("pin latency", (n >= 3 && n <= 4), 1);
      @(posedge hclk);
      drain(0, 4);
      bus_rd(`MIC_OFS_CTL, 32'h12);
      bus_wr(`MIC_OFS_CTL, 32'h10);
      ret_irq();
      ext_irq_pin <= ~s[0];
      repeat (8) @(posedge hclk);
      bus_rd(`MIC_OFS_CTL, 32'h90);
      bus_wr(`MIC_OFS_CTL, 32'h00);
    end
    // Pin left high, service left, nothing pending
    bus_rd(`MIC_OFS_STAT, 32'h08);
    // Each upper port pin in turn
    for (int b = 0; b < 4; b++) begin
      bus_wr(`MIC_OFS_CTL, 32'h88);
      vq.push_back(`MIC_VECTOR);
      upper_port_pins <= upper_port_pins ^ (4'h1 << b);
      drain(0, 12);
      bus_rd(`MIC_OFS_CTL, 32'h09);
      bus_wr(`MIC_OFS_CTL, 32'h08);
      ret_irq();
    end
    // Six peripheral sources behind the group gate
    bus_wr(`MIC_OFS_PEN, 32'h3F);
    bus_wr(`MIC_OFS_CTL, 32'h80);
    for (int i = 0; i < 6; i++) begin
      periph_evt <= 6'h01 << i;
      @(posedge hclk);
      periph_evt <= 6'h00;
      repeat (3) @(posedge hclk);
      bus_rd(`MIC_OFS_PFLAG, 32'h1 << i);
      vq.push_back(`MIC_VECTOR);
      bus_wr(`MIC_OFS_CTL, 32'hC0);
      drain(0, 3);
      bus_wr(`MIC_OFS_PFLAG, 32'h00);
      ret_irq();
      bus_wr(`MIC_OFS_CTL, 32'h80);
    end
    // Reset in mid-run drops the global enable
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    bus_rd(`MIC_OFS_CTL, 32'h00);
    repeat (2) @(posedge hclk);
    close_out();
  end
endmodule : mic_top_test
